// File: adc_spi_pkg.sv
// adc_spi_pkg: constants, types and states for the converter serial loop block.
// assumes one 50 MHz ref_clk domain; all pins are already synchronous to it.
package adc_spi_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int CH_COUNT = 8;
	localparam int DATA_W = 24;
	localparam int WORD_W = 32;
	localparam int REG_COUNT = 32;
	localparam logic [5:0] CTRL_LAST_BIT = 6'h07;

	// ----------------------------------------------------------------
	// address map and loop sets
	// ----------------------------------------------------------------
	localparam logic [4:0] CH_FIRST = 5'h00;
	localparam logic [4:0] CH_LAST = 5'h07;
	localparam logic [4:0] CFG_FIRST = 5'h08;
	localparam logic [4:0] MAP_LAST = 5'h1F;
	localparam logic [4:0] KEY_ADDR = 5'h1F;
	localparam logic [4:0] PHASE_ADDR_A = 5'h0A;
	localparam logic [4:0] PHASE_ADDR_B = 5'h0B;
	localparam logic [4:0] CH_GRP_MASK = 5'h01;
	localparam logic [4:0] CFG_GRP_MASK = 5'h07;

	// ----------------------------------------------------------------
	// codes and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] UNLOCK_KEY = 8'hA5;
	localparam logic [7:0] KEY_RESET = 8'hA5;
	localparam logic [1:0] RD_STATIC = 2'h0;
	localparam logic [1:0] RD_GROUPS = 2'h1;
	localparam logic [1:0] RD_TYPES = 2'h2;
	localparam logic [1:0] RD_FULL = 2'h3;
	localparam logic WR_STATIC = 1'b0;
	localparam logic WR_TYPES = 1'b1;
	localparam logic [1:0] WIDTH_16 = 2'h0;
	localparam logic [1:0] WIDTH_24 = 2'h1;
	localparam logic [5:0] BITS_16 = 6'h10;
	localparam logic [5:0] BITS_24 = 6'h18;
	localparam logic [5:0] BITS_32 = 6'h20;
	localparam logic [1:0] DEV_ADDR_DEFAULT = 2'h1;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] read_loop_sel;
		logic write_loop_sel;
		logic [1:0] word_width;
		logic link_ready_outputs;
		logic ready_idle_drive;
	} spi_cfg_type;

	typedef struct packed {
		logic [2:0] oversample_ratio;
		logic [1:0] prescaler;
		logic ext_clock_select;
		logic ext_reference_select;
	} restart_cfg_type;

	typedef enum logic [2:0] {
		st_idle,
		st_ctrl,
		st_read,
		st_write,
		st_halt
	} spi_state_type;

endpackage

// File: adc_spi_loop_ready.sv
// adc_spi_loop_ready: serial loop engine, ready pulse pin and result latches.
// assumes serial pins sampled on ref_clk (running at twice the master clock
// rate) and converter done pulses arriving one ref_clk cycle long.
`timescale 1ns/100ps

// Overview of operation
// - one control byte per frame; the loop lasts until chip select rises
// - pointer starts at control byte address, advances after each register
// - at last address of set the sequence ends and wraps to first
// - two-bit read loop select: static, groups, types (default), full map
// - one-bit write loop select: static or types (default)
// - serial input ignored after control byte during reads
// - idle-low: previous MSB after read when next word is a channel, new MSB at ready pulse; idle-high holds LSB
// - serial output stays high impedance during whole write transfer
// - write to non-writable address changes nothing, pointer not advanced
// - key not 0xA5 makes every address except 0x1F non-writable
// - phase write or clock, ratio, reference change restarts active converters
// - restart clears all channel results, conversion then resumes alone
// - active-low ready pulse at each conversion end, half master clock long
// - first pulse after settling plus phase delay, then every ready-rate period
// - idle ready pin floats when idle drive is 0, driven high when 1
// - ready pulses run independently of chip select and serial interface
// - ready pin inactive while hardware reset input is low
// - checksum mismatch holds ready pin low while it is asserted
// - first latch stage captures results on ready, all active when linked
// - second stage freezes a channel result at start of its read
// - output shifted on serial clock falling edges, input sampled on rising
// - write key resets to 0xA5, map unlocked after power-up
module adc_spi_loop_ready #(
	parameter logic [1:0] DEV_ADDR = adc_spi_pkg::DEV_ADDR_DEFAULT
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic sdi,
	output logic sdo,
	output logic sdo_oe,
	input wire adc_spi_pkg::spi_cfg_type spi_cfg,
	input wire adc_spi_pkg::restart_cfg_type restart_cfg,
	input wire logic [adc_spi_pkg::DATA_W-1:0] cfg_regs [adc_spi_pkg::REG_COUNT],
	input wire logic [adc_spi_pkg::CH_COUNT-1:0] channel_active,
	input wire logic [adc_spi_pkg::CH_COUNT-1:0] conv_done,
	input wire logic [adc_spi_pkg::CH_COUNT-1:0][adc_spi_pkg::DATA_W-1:0] conv_data,
	input wire logic hw_reset_n,
	input wire logic checksum_mismatch,
	output logic ready_pulse_n,
	output logic ready_oe,
	output logic wr_strobe,
	output logic [4:0] wr_addr,
	output logic [adc_spi_pkg::DATA_W-1:0] wr_data,
	output logic [7:0] write_key,
	output logic converter_restart,
	output logic [adc_spi_pkg::CH_COUNT-1:0] restart_mask
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	adc_spi_pkg::spi_state_type state;
	logic sclk_q;
	logic idle_low;
	logic [5:0] cnt;
	logic [4:0] ptr;
	logic [adc_spi_pkg::WORD_W-1:0] sh;
	logic [adc_spi_pkg::WORD_W-1:0] rx;
	logic msb_pending;
	logic [adc_spi_pkg::CH_COUNT-1:0] captured;
	logic prev_msb;
	logic [adc_spi_pkg::DATA_W-1:0] results [adc_spi_pkg::CH_COUNT];
	adc_spi_pkg::restart_cfg_type restart_prev;
	logic restart_seen;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	function automatic logic [4:0] loop_next(input logic [4:0] a, input logic rd,
		input adc_spi_pkg::spi_cfg_type c);
		logic [4:0] first, last, mask;
		logic is_ch;
		is_ch = (a <= adc_spi_pkg::CH_LAST);
		mask = is_ch ? adc_spi_pkg::CH_GRP_MASK : adc_spi_pkg::CFG_GRP_MASK;
		first = a;
		last = a;
		if (rd) begin
			case (c.read_loop_sel)
				adc_spi_pkg::RD_STATIC: ;
				adc_spi_pkg::RD_GROUPS: begin
					first = a & ~mask;
					last = a | mask;
				end
				adc_spi_pkg::RD_TYPES: begin
					first = is_ch ? adc_spi_pkg::CH_FIRST : adc_spi_pkg::CFG_FIRST;
					last = is_ch ? adc_spi_pkg::CH_LAST : adc_spi_pkg::MAP_LAST;
				end
				default: begin
					first = adc_spi_pkg::CH_FIRST;
					last = adc_spi_pkg::MAP_LAST;
				end
			endcase
		end else if (c.write_loop_sel == adc_spi_pkg::WR_TYPES) begin
			first = adc_spi_pkg::CFG_FIRST;
			last = adc_spi_pkg::MAP_LAST;
		end
		return (a == last) ? first : a + 5'h01;
	endfunction

	function automatic logic [adc_spi_pkg::WORD_W-1:0] word_at(input logic [4:0] a);
		logic [adc_spi_pkg::DATA_W-1:0] d;
		if (a <= adc_spi_pkg::CH_LAST)
			d = results[a[2:0]];
		else if (a == adc_spi_pkg::KEY_ADDR)
			d = {cfg_regs[a][adc_spi_pkg::DATA_W-1:8], write_key};
		else
			d = cfg_regs[a];
		return {d, 8'h00};
	endfunction

	wire rise = sclk & ~sclk_q;
	wire fall = ~sclk & sclk_q;
	wire [5:0] word_bits = (spi_cfg.word_width == adc_spi_pkg::WIDTH_16) ? adc_spi_pkg::BITS_16 :
		(spi_cfg.word_width == adc_spi_pkg::WIDTH_24) ? adc_spi_pkg::BITS_24 :
		adc_spi_pkg::BITS_32;
	wire [5:0] last_bit = word_bits - 6'h01;
	wire [7:0] ctrl_byte = {rx[6:0], sdi};
	wire [4:0] ctrl_addr = ctrl_byte[5:1];
	wire ctrl_done = (state == adc_spi_pkg::st_ctrl) && rise && (cnt == adc_spi_pkg::CTRL_LAST_BIT);
	wire dev_match = (ctrl_byte[7:6] == DEV_ADDR);
	wire [adc_spi_pkg::WORD_W-1:0] rx_next = {rx[adc_spi_pkg::WORD_W-2:0], sdi};
	wire [adc_spi_pkg::DATA_W-1:0] rx_data =
		(spi_cfg.word_width == adc_spi_pkg::WIDTH_16) ? {rx_next[15:0], 8'h00} :
		(spi_cfg.word_width == adc_spi_pkg::WIDTH_24) ? rx_next[23:0] : rx_next[31:8];
	wire [4:0] next_rd_ptr = loop_next(ptr, 1'b1, spi_cfg);
	wire [4:0] next_wr_ptr = loop_next(ptr, 1'b0, spi_cfg);
	wire [adc_spi_pkg::WORD_W-1:0] next_word = word_at(next_rd_ptr);
	wire next_is_ch = (next_rd_ptr <= adc_spi_pkg::CH_LAST);
	wire [adc_spi_pkg::WORD_W-1:0] ctrl_word = word_at(ctrl_addr);
	wire [adc_spi_pkg::WORD_W-1:0] ptr_word = word_at(ptr);
	// lock keeps only key address writable
	wire writable = (ptr >= adc_spi_pkg::CFG_FIRST) &&
		((write_key == adc_spi_pkg::UNLOCK_KEY) || (ptr == adc_spi_pkg::KEY_ADDR));
	wire wr_done = (state == adc_spi_pkg::st_write) && rise && (cnt == last_bit);
	wire wr_fire = wr_done && writable;
	wire rd_done = (state == adc_spi_pkg::st_read) && fall &&
		(idle_low ? (cnt == word_bits) : (cnt == last_bit));
	wire phase_wr = wr_fire &&
		((ptr == adc_spi_pkg::PHASE_ADDR_A) || (ptr == adc_spi_pkg::PHASE_ADDR_B));
	wire cfg_changed = restart_seen && (restart_cfg != restart_prev);
	wire restart_now = phase_wr || cfg_changed;
	// linked capture of all active channels
	wire any_done = |(conv_done & channel_active);
	wire [adc_spi_pkg::CH_COUNT-1:0] capture = spi_cfg.link_ready_outputs ?
		({adc_spi_pkg::CH_COUNT{any_done}} & channel_active) : conv_done;
	wire ready_evt = spi_cfg.link_ready_outputs ? any_done : |conv_done;

	// ----------------------------------------------------------------
	// serial engine
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state <= adc_spi_pkg::st_idle;
			sclk_q <= 1'b0;
			idle_low <= 1'b0;
			cnt <= 6'h00;
			ptr <= 5'h00;
			sh <= 32'h00000000;
			rx <= 32'h00000000;
			sdo <= 1'b0;
			sdo_oe <= 1'b0;
			msb_pending <= 1'b0;
			captured <= '0;
			prev_msb <= 1'b0;
			wr_strobe <= 1'b0;
			wr_addr <= 5'h00;
			wr_data <= 24'h000000;
			write_key <= adc_spi_pkg::KEY_RESET;
		end else if (clk_en) begin
			sclk_q <= sclk;
			captured <= capture;
			wr_strobe <= 1'b0;
			if (cs_n) begin
				// frame ends only on chip select high
				state <= adc_spi_pkg::st_idle;
				sdo_oe <= 1'b0;
				msb_pending <= 1'b0;
			end else begin
				case (state)
					adc_spi_pkg::st_idle: begin
						state <= adc_spi_pkg::st_ctrl;
						idle_low <= ~sclk;
						cnt <= 6'h00;
					end
					adc_spi_pkg::st_ctrl: begin
						if (rise) begin
							rx <= rx_next;
							cnt <= cnt + 6'h01;
						end
						if (ctrl_done) begin
							cnt <= 6'h00;
							ptr <= ctrl_addr;
							if (!dev_match) begin
								state <= adc_spi_pkg::st_halt;
							end else if (ctrl_byte[0]) begin
								state <= adc_spi_pkg::st_read;
								sh <= ctrl_word;
								prev_msb <= ctrl_word[adc_spi_pkg::WORD_W-1];
								sdo_oe <= 1'b1;
							end else begin
								state <= adc_spi_pkg::st_write;
							end
						end
					end
					adc_spi_pkg::st_read: begin
						if (fall) begin
							msb_pending <= 1'b0;
							sdo <= sh[adc_spi_pkg::WORD_W-1];
							sh <= {sh[adc_spi_pkg::WORD_W-2:0], 1'b0};
							cnt <= cnt + 6'h01;
							// idle-high keeps the last bit until the next fall
							if (rd_done) begin
								ptr <= next_rd_ptr;
								prev_msb <= next_word[adc_spi_pkg::WORD_W-1];
								sh <= next_word;
								cnt <= 6'h00;
							end
							// channel word: previous MSB, new one waits for ready; other words show their own MSB at once
							if (rd_done && idle_low) begin
								sh <= {next_word[adc_spi_pkg::WORD_W-2:0], 1'b0};
								cnt <= 6'h01;
								sdo <= next_is_ch ? prev_msb : next_word[adc_spi_pkg::WORD_W-1];
								msb_pending <= next_is_ch;
							end
						end else if (msb_pending && captured[ptr[2:0]]) begin
							// new word shown once its result is latched
							sdo <= ptr_word[adc_spi_pkg::WORD_W-1];
							sh <= {ptr_word[adc_spi_pkg::WORD_W-2:0], 1'b0};
							prev_msb <= ptr_word[adc_spi_pkg::WORD_W-1];
							msb_pending <= 1'b0;
						end
					end
					adc_spi_pkg::st_write: begin
						if (rise) begin
							rx <= rx_next;
							cnt <= cnt + 6'h01;
						end
						if (wr_fire) begin
							wr_strobe <= 1'b1;
							wr_addr <= ptr;
							wr_data <= rx_data;
							ptr <= next_wr_ptr;
							cnt <= 6'h00;
							if (ptr == adc_spi_pkg::KEY_ADDR)
								write_key <= rx_data[7:0];
						end else if (wr_done) begin
							state <= adc_spi_pkg::st_halt;
						end
					end
					default: begin
						state <= adc_spi_pkg::st_halt;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// result latches and restart
	// ----------------------------------------------------------------
	for (genvar i = 0; i < adc_spi_pkg::CH_COUNT; i++) begin : g_latch
		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst)
				results[i] <= 24'h000000;
			else if (clk_en && restart_now)
				results[i] <= 24'h000000;
			else if (clk_en && capture[i])
				results[i] <= conv_data[i];
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			restart_prev <= '0;
			restart_seen <= 1'b0;
			converter_restart <= 1'b0;
			restart_mask <= 8'h00;
		end else if (clk_en) begin
			restart_prev <= restart_cfg;
			restart_seen <= 1'b1;
			// restart only converters that are running
			converter_restart <= restart_now;
			restart_mask <= restart_now ? channel_active : 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// ready pin
	// ----------------------------------------------------------------
	// sequencing of pulses (settling, phase, rate) lives in the converter;
	// this stage only shapes and drives them, ignoring chip select
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ready_pulse_n <= 1'b1;
			ready_oe <= 1'b0;
		end else if (clk_en) begin
			// hardware reset falls through to the idle drive
			if (hw_reset_n && checksum_mismatch) begin
				ready_pulse_n <= 1'b0;
				ready_oe <= 1'b1;
			end else if (hw_reset_n && ready_evt) begin
				// one ref_clk cycle is half a master period
				ready_pulse_n <= 1'b0;
				ready_oe <= 1'b1;
			end else begin
				ready_pulse_n <= 1'b1;
				ready_oe <= spi_cfg.ready_idle_drive;
			end
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_key_reset_val: assert property (@(posedge ref_clk) $fell(rst) |-> write_key == 8'hA5)
		else $error("write key not unlocked after reset");
	a_write_no_drive: assert property (@(posedge ref_clk) disable iff (rst)
		state == adc_spi_pkg::st_write |-> !sdo_oe)
		else $error("serial output driven during write");
	a_locked_write_block: assert property (@(posedge ref_clk) disable iff (rst)
		wr_strobe && wr_addr != 5'h1F |-> $past(write_key) == 8'hA5)
		else $error("write taken while map locked");
	a_halt_ptr_hold: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && state == adc_spi_pkg::st_halt && !cs_n |=> $stable(ptr) && !wr_strobe)
		else $error("pointer moved after refused write");
	a_ready_pulse_low: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && ready_evt && hw_reset_n |=> !ready_pulse_n && ready_oe)
		else $error("ready pulse missing");
	a_ready_reset_idle: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && !hw_reset_n |=> ready_pulse_n && ready_oe == $past(spi_cfg.ready_idle_drive))
		else $error("ready active during hardware reset");
	a_mismatch_hold_low: assert property (@(posedge ref_clk) disable iff (rst)
		(clk_en && hw_reset_n && checksum_mismatch) [*2] |=> !ready_pulse_n)
		else $error("ready not held low on mismatch");
	a_phase_restart: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && phase_wr |=> converter_restart && restart_mask == $past(channel_active))
		else $error("phase write did not restart converters");
	a_restart_clears: assert property (@(posedge ref_clk) disable iff (rst)
		converter_restart |-> results[0] == 24'h000000 && results[7] == 24'h000000)
		else $error("results not cleared on restart");
	a_types_wrap: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && rd_done && !cs_n && ptr == 5'h07 && spi_cfg.read_loop_sel == 2'h2
		|=> ptr == 5'h00)
		else $error("read pointer did not wrap to set start");
	a_ctrl_start_ptr: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && ctrl_done && !cs_n |=> ptr == $past(ctrl_addr))
		else $error("pointer not loaded from control byte");

endmodule // adc_spi_loop_ready

// File: spi_host_model.sv
// spi_host_model: serial host that frames transfers for the loop block.
// assumes ref_clk is the bench clock; its tasks are called from the testbench.
`timescale 1ns/100ps
module spi_host_model (
	input wire logic ref_clk,
	output logic cs_n,
	output logic sclk,
	output logic sdi,
	input wire logic sdo
);
	logic idle_hi;

	initial begin
		idle_hi = 1'b1;
		cs_n = 1'b1;
		sclk = 1'b1;
		sdi = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	// shift on fall, sample on rise
	task automatic xbit(input logic b, output logic s);
		sclk = 1'b0;
		sdi = b;
		tick(3);
		s = sdo;
		sclk = 1'b1;
		tick(2);
	endtask

	task automatic start(input logic hi, input logic [7:0] ctrl);
		logic s;
		idle_hi = hi;
		sclk = hi;
		tick(2);
		cs_n = 1'b0;
		tick(2);
		for (int i = 7; i >= 0; i--)
			xbit(ctrl[i], s);
	endtask

	task automatic word(input logic [23:0] d, output logic [23:0] q);
		logic s;
		for (int i = 23; i >= 0; i--) begin
			xbit(d[i], s);
			q[i] = s;
		end
	endtask

	task automatic fall();
		sclk = 1'b0;
		tick(2);
	endtask

	// released data line shows the inverse of its last value
	task automatic stop();
		sclk = idle_hi;
		tick(2);
		cs_n = 1'b1;
		sdi = ~sdi;
		tick(3);
	endtask
endmodule // spi_host_model

// File: testbench.sv
// testbench: serial frames and converter events checked against expected values.
// assumes spi_host_model drives the serial pins; strobes are gathered on falling edges.
`timescale 1ns/100ps
module testbench;
	logic ref_clk, rst, cs_n, sclk, sdi, sdo, sdo_oe, hw_reset_n, checksum_mismatch, wr_frame;
	logic clk_en;
	logic ready_pulse_n, ready_oe, wr_strobe, converter_restart;
	adc_spi_pkg::spi_cfg_type spi_cfg;
	adc_spi_pkg::restart_cfg_type restart_cfg;
	logic [23:0] cfg_regs [32];
	logic [7:0] channel_active, conv_done, restart_mask, write_key, rs_mask;
	logic [7:0][23:0] conv_data;
	logic [4:0] wr_addr;
	logic [23:0] wr_data, w;
	logic [23:0] res [8];
	logic [4:0] wq_a [$];
	logic [23:0] wq_d [$];
	logic [23:0] rq [$];
	logic [4:0] ra [4] = '{5'h02, 5'h00, 5'h06, 5'h1E};
	logic [4:0] ea [4][3] = '{'{5'h02, 5'h02, 5'h02}, '{5'h00, 5'h01, 5'h00},
		'{5'h06, 5'h07, 5'h00}, '{5'h1E, 5'h1F, 5'h00}};
	logic [6:0] flip [4] = '{7'h10, 7'h04, 7'h02, 7'h01};
	int error_cnt, checks, rs_cnt, oe_in_wr;

	adc_spi_loop_ready adc_spi_loop_ready_i (
		.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .cs_n(cs_n), .sclk(sclk),
		.sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .spi_cfg(spi_cfg), .restart_cfg(restart_cfg),
		.cfg_regs(cfg_regs), .channel_active(channel_active), .conv_done(conv_done),
		.conv_data(conv_data), .hw_reset_n(hw_reset_n), .checksum_mismatch(checksum_mismatch),
		.ready_pulse_n(ready_pulse_n), .ready_oe(ready_oe), .wr_strobe(wr_strobe),
		.wr_addr(wr_addr), .wr_data(wr_data), .write_key(write_key),
		.converter_restart(converter_restart), .restart_mask(restart_mask)
	);

	spi_host_model spi_host_model_i (
		.ref_clk(ref_clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo)
	);

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	// falling edge keeps the monitor clear of the launching edge
	always @(negedge ref_clk) begin
		if (wr_strobe === 1'b1) begin
			wq_a.push_back(wr_addr);
			wq_d.push_back(wr_data);
		end
		if (converter_restart === 1'b1) begin
			rs_cnt++;
			rs_mask = restart_mask;
		end
		if (wr_frame && sdo_oe !== 1'b0)
			oe_in_wr++;
	end

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic conclude();
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	// one conversion end; show is low when the pin must stay quiet
	task automatic fire(input int c, input logic show);
		conv_done[c] = 1'b1;
		tick(1);
		conv_done = '0;
		for (int i = 0; i < 8; i++)
			if (i == c || (spi_cfg.link_ready_outputs && channel_active[i]))
				res[i] = conv_data[i];
		chk("ready_low", {ready_pulse_n, ready_oe},
			show ? 2'b01 : {1'b1, spi_cfg.ready_idle_drive});
		tick(1);
		chk("ready_idle", {ready_pulse_n, ready_oe}, {1'b1, spi_cfg.ready_idle_drive});
	endtask

	// reads send a toggling pattern that the block must ignore
	task automatic frame(input logic hi, input logic [4:0] a, input logic rw, input int n,
			input logic [23:0] d);
		rq.delete();
		wr_frame = !rw;
		spi_host_model_i.start(hi, {adc_spi_pkg::DEV_ADDR_DEFAULT, a, rw});
		for (int k = 0; k < n; k++) begin
			spi_host_model_i.word(rw ? 24'hAAAAAA : d + {8'(k), 8'h00}, w);
			rq.push_back(w);
		end
	endtask

	task automatic close();
		spi_host_model_i.stop();
		wr_frame = 1'b0;
	endtask

	task automatic wexp(input logic [4:0] a, input logic [23:0] d);
		chk("wr_count", wq_a.size() > 0, 1);
		if (wq_a.size() > 0) begin
			chk("wr_addr", wq_a.pop_front(), a);
			chk("wr_data", wq_d.pop_front(), d);
		end
	endtask

	function automatic logic [23:0] expv(input logic [4:0] a);
		if (a < adc_spi_pkg::CFG_FIRST)
			return res[a[2:0]];
		if (a == adc_spi_pkg::KEY_ADDR)
			return {cfg_regs[a][23:8], adc_spi_pkg::KEY_RESET};
		return cfg_regs[a];
	endfunction

	initial begin
		#400000;
		$display("ERROR watchdog expired");
		error_cnt++;
		conclude();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		rst = 1'b1;
		wr_frame = 1'b0;
		clk_en = 1'b1;
		hw_reset_n = 1'b1;
		checksum_mismatch = 1'b0;
		conv_done = '0;
		channel_active = 8'hFF;
		restart_cfg = '0;
		spi_cfg = '{adc_spi_pkg::RD_TYPES, adc_spi_pkg::WR_TYPES, adc_spi_pkg::WIDTH_24, 1'b1, 1'b1};
		for (int i = 0; i < 8; i++)
			conv_data[i] = {4'h9, 4'(i), 16'h5A3D};
		for (int i = 0; i < 32; i++)
			cfg_regs[i] = 24'hC30000 | 24'(i);
		repeat (8) @(posedge ref_clk);
		#1;
		rst = 1'b0;
		tick(2);
		chk("key_reset", write_key, 8'hA5);
		for (int v = 0; v < 2; v++) begin
			spi_cfg.ready_idle_drive = v[0];
			tick(2);
			fire(0, 1'b1);
		end
		hw_reset_n = 1'b0;
		tick(2);
		fire(3, 1'b0);
		hw_reset_n = 1'b1;
		checksum_mismatch = 1'b1;
		tick(3);
		chk("ready_latched", {ready_pulse_n, ready_oe}, 2'b01);
		tick(4);
		chk("ready_latched", {ready_pulse_n, ready_oe}, 2'b01);
		checksum_mismatch = 1'b0;
		tick(2);
		spi_cfg.link_ready_outputs = 1'b0;
		for (int i = 0; i < 8; i++)
			conv_data[i] = {4'h3, 4'(i), 16'hC3A1};
		fire(1, 1'b1);
		for (int m = 0; m < 4; m++) begin
			spi_cfg.read_loop_sel = m[1:0];
			frame(1'b1, ra[m], 1'b1, 3, 24'h0);
			close();
			for (int k = 0; k < 3; k++)
				chk("read_word", rq[k], expv(ea[m][k]));
		end
		spi_cfg.read_loop_sel = adc_spi_pkg::RD_STATIC;
		frame(1'b0, 5'h00, 1'b1, 1, 24'h0);
		spi_host_model_i.fall();
		chk("sdo_prev_msb", sdo, res[0][23]);
		chk("sdo_oe_read", sdo_oe, 1'b1);
		fire(0, 1'b1);
		chk("sdo_new_msb", sdo, conv_data[0][23]);
		close();
		frame(1'b1, 5'h02, 1'b1, 1, 24'h0);
		chk("sdo_hold_lsb", sdo, res[2][0]);
		close();
		frame(1'b1, 5'h1E, 1'b0, 3, 24'h1234A5);
		close();
		wexp(5'h1E, 24'h1234A5);
		wexp(5'h1F, 24'h1235A5);
		wexp(5'h08, 24'h1236A5);
		chk("sdo_oe_write", oe_in_wr, 0);
		spi_cfg.write_loop_sel = adc_spi_pkg::WR_STATIC;
		frame(1'b1, 5'h09, 1'b0, 2, 24'h000111);
		close();
		wexp(5'h09, 24'h000111);
		wexp(5'h09, 24'h000211);
		frame(1'b1, 5'h03, 1'b0, 2, 24'h000333);
		close();
		chk("no_strobe", wq_a.size(), 0);
		frame(1'b1, 5'h09, 1'b0, 1, 24'h000444);
		close();
		wexp(5'h09, 24'h000444);
		frame(1'b1, 5'h09, 1'b0, 0, 24'h0);
		repeat (12) spi_host_model_i.xbit(1'b1, w[0]);
		close();
		chk("partial_word", wq_a.size(), 0);
		spi_cfg.word_width = adc_spi_pkg::WIDTH_16;
		frame(1'b1, 5'h09, 1'b0, 1, 24'h13579B);
		close();
		wexp(5'h09, 24'h135700);
		chk("tail_dropped", wq_a.size(), 0);
		spi_cfg.word_width = adc_spi_pkg::WIDTH_24;
		spi_host_model_i.start(1'b1, {2'h2, 5'h09, 1'b0});
		spi_host_model_i.word(24'h000555, w);
		close();
		chk("dev_refused", wq_a.size(), 0);
		frame(1'b1, 5'h1F, 1'b0, 1, 24'h000000);
		close();
		wexp(5'h1F, 24'h000000);
		chk("key_locked", write_key, 8'h00);
		frame(1'b1, 5'h08, 1'b0, 1, 24'h000777);
		close();
		chk("locked_write", wq_a.size(), 0);
		frame(1'b1, 5'h1F, 1'b0, 1, 24'h0000A5);
		close();
		wexp(5'h1F, 24'h0000A5);
		chk("key_open", write_key, 8'hA5);
		channel_active = 8'h5A;
		rs_cnt = 0;
		for (int k = 0; k < 2; k++) begin
			frame(1'b1, adc_spi_pkg::PHASE_ADDR_A, 1'b0, 1, 24'h000010);
			close();
		end
		for (int k = 0; k < 4; k++) begin
			restart_cfg = restart_cfg ^ flip[k];
			tick(3);
		end
		chk("restart_count", rs_cnt, 6);
		chk("restart_mask", rs_mask, 8'h5A);
		frame(1'b1, 5'h01, 1'b1, 1, 24'h0);
		close();
		chk("cleared", rq[0], 24'h000000);
		// reads follow the ready pulse, so no status polling is needed
		fire(6, 1'b1);
		frame(1'b1, 5'h06, 1'b1, 1, 24'h0);
		close();
		chk("resumed", rq[0], res[6]);
		// clock enable low must freeze the pin and the result latches
		clk_en = 1'b0;
		fire(2, 1'b0);
		clk_en = 1'b1;
		frame(1'b1, 5'h02, 1'b1, 1, 24'h0);
		close();
		chk("frozen", rq[0], 24'h000000);
		conclude();
	end
endmodule // testbench
